// ==== hw/dual_timer_counter_toggle.sv ====
// Top: two timer/counters with gating, overflow flags, toggle pins and baud tick
`timescale 1ns/100ps
`default_nettype none

module dual_timer_counter_toggle (
  input  wire logic                         core_clk_i,
  input  wire logic                         rstn_i,
  input  wire logic [7:0]                   timer_mode_register_i,
  input  wire logic                         run_control_bit_zero_i,
  input  wire logic                         run_control_bit_one_i,
  input  wire logic                         toggle_enable_zero_i,
  input  wire logic                         toggle_enable_one_i,
  input  wire logic                         flag_clear_zero_i,
  input  wire logic                         flag_clear_one_i,
  input  wire logic                         load_zero_i,
  input  wire logic                         load_one_i,
  input  wire dual_timer_pkg::timer_count_t load_val_i,
  input  wire logic                         count_pin_zero_i,
  input  wire logic                         count_pin_one_i,
  input  wire logic                         gating_input_pin_zero_i,
  input  wire logic                         gating_input_pin_one_i,
  output logic                              count_pin_zero_o,
  output logic                              count_pin_zero_oe_o,
  output logic                              count_pin_one_o,
  output logic                              count_pin_one_oe_o,
  output logic                              overflow_flag_zero_o,
  output logic                              timer_one_overflow_flag_o,
  output logic                              irq_zero_o,
  output logic                              irq_one_o,
  output logic                              baud_tick_o,
  output var dual_timer_pkg::timer_count_t  count_zero_o,
  output var dual_timer_pkg::timer_count_t  count_one_o
);

  // ****************************************************************
  // Machine cycle divider
  // ****************************************************************
  logic [dual_timer_pkg::PRESCALE_W-1:0] prescale;
  logic                                  mc_tick;

  assign mc_tick = prescale == dual_timer_pkg::PRESCALE_LAST;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      prescale <= '0;
    end else begin
      prescale <= mc_tick ? '0 : prescale + 3'h1;
    end
  end

  // ****************************************************************
  // Mode register decode
  // ****************************************************************
  dual_timer_pkg::timer_cfg_t cfg_zero;
  dual_timer_pkg::timer_cfg_t cfg_one;

  // Gate at bit 7 for timer one and bit 3 for timer zero follows from the nibble layout
  assign cfg_zero = dual_timer_pkg::timer_cfg_t'(
    timer_mode_register_i[dual_timer_pkg::TIMER_ZERO_LSB +: dual_timer_pkg::MODE_NIBBLE_W]);
  assign cfg_one  = dual_timer_pkg::timer_cfg_t'(
    timer_mode_register_i[dual_timer_pkg::TIMER_ONE_LSB +: dual_timer_pkg::MODE_NIBBLE_W]);

  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  logic gate_zero_lvl;
  logic gate_one_lvl;
  logic fall_zero;
  logic fall_one;

  // Count pins are only read through the sampler; the level must last a machine cycle
  edge_sampler u_pin_zero (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .mc_tick_i  (mc_tick),
    .pin_i      (count_pin_zero_i),
    .level_o    (),
    .fall_o     (fall_zero)
  );

  edge_sampler u_pin_one (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .mc_tick_i  (mc_tick),
    .pin_i      (count_pin_one_i),
    .level_o    (),
    .fall_o     (fall_one)
  );

  edge_sampler u_gate_zero (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .mc_tick_i  (mc_tick),
    .pin_i      (gating_input_pin_zero_i),
    .level_o    (gate_zero_lvl),
    .fall_o     ()
  );

  edge_sampler u_gate_one (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .mc_tick_i  (mc_tick),
    .pin_i      (gating_input_pin_one_i),
    .level_o    (gate_one_lvl),
    .fall_o     ()
  );

  // ****************************************************************
  // Count enables
  // ****************************************************************
  logic run_zero;
  logic run_one;
  logic one_stopped;
  logic split_mode;
  logic inc_zero_low;
  logic inc_zero_high;
  logic inc_one;

  assign split_mode  = cfg_zero.mode == dual_timer_pkg::MODE_SPLIT;
  assign one_stopped = cfg_one.mode == dual_timer_pkg::MODE_SPLIT;

  assign run_zero = run_control_bit_zero_i & (~cfg_zero.gate | gate_zero_lvl);
  assign run_one  = run_control_bit_one_i & (~cfg_one.gate | gate_one_lvl) & ~one_stopped;

  // Edge strobe lands one clock after the tick that takes the sample pair; counted in that same clock
  assign inc_zero_low  = run_zero & (cfg_zero.counter_sel ? fall_zero : mc_tick);
  assign inc_zero_high = split_mode & run_control_bit_one_i & mc_tick;
  assign inc_one       = run_one & (cfg_one.counter_sel ? fall_one : mc_tick);

  // ****************************************************************
  // Counters
  // ****************************************************************
  dual_timer_pkg::timer_count_t count_zero;
  dual_timer_pkg::timer_count_t count_one;
  logic                         ovf_zero_low;
  logic                         ovf_zero_high;
  logic                         ovf_one;

  count_unit u_count_zero (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .mode_i     (cfg_zero.mode),
    .low_inc_i  (inc_zero_low),
    .high_inc_i (inc_zero_high),
    .load_i     (load_zero_i),
    .load_val_i (load_val_i),
    .count_o    (count_zero),
    .low_ovf_o  (ovf_zero_low),
    .high_ovf_o (ovf_zero_high)
  );

  // Timer one takes the split case with both increments low; it is simply held while in mode 3
  count_unit u_count_one (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .mode_i     (cfg_one.mode),
    .low_inc_i  (inc_one),
    .high_inc_i (1'b0),
    .load_i     (load_one_i),
    .load_val_i (load_val_i),
    .count_o    (count_one),
    .low_ovf_o  (ovf_one),
    .high_ovf_o ()
  );

  // ****************************************************************
  // Overflow flags
  // ****************************************************************
  logic set_flag_zero;
  logic set_flag_one;

  assign set_flag_zero = ovf_zero_low;
  // In split mode timer one's flag belongs to timer zero's high byte
  assign set_flag_one  = split_mode ? ovf_zero_high : ovf_one;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      overflow_flag_zero_o      <= 1'b0;
      timer_one_overflow_flag_o <= 1'b0;
      irq_zero_o                <= 1'b0;
      irq_one_o                 <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      overflow_flag_zero_o      <= set_flag_zero | (overflow_flag_zero_o & ~flag_clear_zero_i);
      timer_one_overflow_flag_o <= set_flag_one | (timer_one_overflow_flag_o & ~flag_clear_one_i);
      irq_zero_o                <= set_flag_zero | (overflow_flag_zero_o & ~flag_clear_zero_i);
      irq_one_o                 <= set_flag_one | (timer_one_overflow_flag_o & ~flag_clear_one_i);
    end
  end

  // ****************************************************************
  // Baud tick and count mirrors
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      baud_tick_o  <= 1'b0;
      count_zero_o <= '0;
      count_one_o  <= '0;
    end else begin
      baud_tick_o  <= ovf_one;
      count_zero_o <= count_zero;
      count_one_o  <= count_one;
    end
  end

  // ****************************************************************
  // Toggle outputs
  // ****************************************************************
  logic tog_ovf_zero;
  logic tog_ovf_one;

  assign tog_ovf_zero = ovf_zero_low;
  assign tog_ovf_one  = split_mode ? ovf_zero_high : ovf_one;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      count_pin_zero_o    <= 1'b1;
      count_pin_one_o     <= 1'b1;
      count_pin_zero_oe_o <= 1'b0;
      count_pin_one_oe_o  <= 1'b0;
    end else begin
      count_pin_zero_oe_o <= toggle_enable_zero_i;
      count_pin_one_oe_o  <= toggle_enable_one_i;
      if (!toggle_enable_zero_i) begin
        count_pin_zero_o <= 1'b1;
      end else if (tog_ovf_zero) begin
        count_pin_zero_o <= ~count_pin_zero_o;
      end
      if (!toggle_enable_one_i) begin
        count_pin_one_o <= 1'b1;
      end else if (tog_ovf_one) begin
        count_pin_one_o <= ~count_pin_one_o;
      end
    end
  end

endmodule : dual_timer_counter_toggle

`default_nettype wire

// ==== hw/dual_timer_pkg.sv ====
// Package: constants and carrier types for the dual timer/counter block
package dual_timer_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLKS_PER_MACHINE_CYCLE = 6;
  localparam int unsigned PRESCALE_W             = 3;
  localparam logic [2:0]  PRESCALE_LAST          = 3'h5;

  // ****************************************************************
  // Mode register layout, one nibble per timer
  // ****************************************************************
  localparam int unsigned MODE_NIBBLE_W   = 4;
  localparam int unsigned MODE_GATE_BIT   = 3;
  localparam int unsigned MODE_SEL_BIT    = 2;
  localparam int unsigned MODE_HIGH_BIT   = 1;
  localparam int unsigned MODE_LOW_BIT    = 0;
  localparam int unsigned TIMER_ONE_LSB   = 4;
  localparam int unsigned TIMER_ZERO_LSB  = 0;
  localparam logic [7:0]  MODE_RESET      = 8'h00;

  // ****************************************************************
  // Count layout
  // ****************************************************************
  localparam int unsigned LOW13_W         = 5;
  localparam logic [7:0]  BYTE_ALL_ONES   = 8'hff;
  localparam logic [4:0]  LOW13_ALL_ONES  = 5'h1f;
  localparam logic [7:0]  COUNT_RESET     = 8'h00;

  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_AUTORELOAD,
    MODE_SPLIT
  } timer_mode_t;

  // Per-timer control nibble decoded from the mode register
  typedef struct packed {
    logic        gate;
    logic        counter_sel;
    timer_mode_t mode;
  } timer_cfg_t;

  // Count pair of one timer
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } timer_count_t;

endpackage : dual_timer_pkg

// ==== hw/edge_sampler.sv ====
// Edge sampler: synchronises a pin and detects a 1-to-0 step per machine cycle
`timescale 1ns/100ps
`default_nettype none

module edge_sampler (
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  input  wire logic mc_tick_i,
  input  wire logic pin_i,
  output var  logic level_o,
  output var  logic fall_o
);

  logic sync_a;
  logic sync_b;
  logic sample;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      sync_a  <= 1'b0;
      sync_b  <= 1'b0;
      sample  <= 1'b0;
      fall_o  <= 1'b0;
    end else begin
      sync_a <= pin_i;
      sync_b <= sync_a;
      fall_o <= 1'b0;
      if (mc_tick_i) begin
        sample <= sync_b;
        fall_o <= sample & ~sync_b;
      end
    end
  end

  assign level_o = sync_b;

endmodule : edge_sampler

`default_nettype wire

// ==== hw/count_unit.sv ====
// Count unit: one 16-bit timer with 13-bit, 16-bit, reload and split layouts
`timescale 1ns/100ps
`default_nettype none

module count_unit (
  input  wire logic                        core_clk_i,
  input  wire logic                        rstn_i,
  input  wire dual_timer_pkg::timer_mode_t mode_i,
  input  wire logic                        low_inc_i,
  input  wire logic                        high_inc_i,
  input  wire logic                        load_i,
  input  wire dual_timer_pkg::timer_count_t load_val_i,
  output var  dual_timer_pkg::timer_count_t count_o,
  output var  logic                        low_ovf_o,
  output var  logic                        high_ovf_o
);

  dual_timer_pkg::timer_count_t next_count;
  logic                         low13_wrap;
  logic                         low_wrap;
  logic                         high_wrap;

  assign low13_wrap = count_o.low[dual_timer_pkg::LOW13_W-1:0] == dual_timer_pkg::LOW13_ALL_ONES;
  assign low_wrap   = count_o.low == dual_timer_pkg::BYTE_ALL_ONES;
  assign high_wrap  = count_o.high == dual_timer_pkg::BYTE_ALL_ONES;

  always_comb begin
    next_count = count_o;
    low_ovf_o  = 1'b0;
    high_ovf_o = 1'b0;
    case (mode_i)
      dual_timer_pkg::MODE_13BIT: begin
        if (low_inc_i) begin
          // Upper three low bits are left alone; they carry no meaning here
          next_count.low[dual_timer_pkg::LOW13_W-1:0] =
            count_o.low[dual_timer_pkg::LOW13_W-1:0] + 5'h01;
          if (low13_wrap) begin
            next_count.high = count_o.high + 8'h01;
            low_ovf_o       = high_wrap;
          end
        end
      end
      dual_timer_pkg::MODE_16BIT: begin
        if (low_inc_i) begin
          next_count.low = count_o.low + 8'h01;
          if (low_wrap) begin
            next_count.high = count_o.high + 8'h01;
            low_ovf_o       = high_wrap;
          end
        end
      end
      dual_timer_pkg::MODE_AUTORELOAD: begin
        if (low_inc_i) begin
          next_count.low = low_wrap ? count_o.high : count_o.low + 8'h01;
          low_ovf_o      = low_wrap;
        end
      end
      dual_timer_pkg::MODE_SPLIT: begin
        if (low_inc_i) begin
          next_count.low = count_o.low + 8'h01;
          low_ovf_o      = low_wrap;
        end
        if (high_inc_i) begin
          next_count.high = count_o.high + 8'h01;
          high_ovf_o      = high_wrap;
        end
      end
      default: begin
        next_count = count_o;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      count_o <= {dual_timer_pkg::COUNT_RESET, dual_timer_pkg::COUNT_RESET};
    end else if (load_i) begin
      count_o <= load_val_i;
    end else begin
      count_o <= next_count;
    end
  end

endmodule : count_unit

`default_nettype wire

// ==== testbench/dual_timer_monitor.sv ====
// Port-level assertions for the dual timer/counter
`timescale 1ns/100ps
`default_nettype none

module dual_timer_monitor (
  input wire logic                         core_clk_i,
  input wire logic                         rstn_i,
  input wire logic [7:0]                   timer_mode_register_i,
  input wire logic                         run_control_bit_zero_i,
  input wire logic                         load_zero_i,
  input wire logic                         load_one_i,
  input wire logic                         flag_clear_zero_i,
  input wire logic                         toggle_enable_zero_i,
  input wire logic                         count_pin_zero_o,
  input wire logic                         overflow_flag_zero_o,
  input wire logic                         timer_one_overflow_flag_o,
  input wire logic                         irq_zero_o,
  input wire logic                         baud_tick_o,
  input wire dual_timer_pkg::timer_count_t count_zero_o,
  input wire dual_timer_pkg::timer_count_t count_one_o
);
  // ****
  // Checks
  // ****
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_flag_holds_set: assert property (overflow_flag_zero_o && !flag_clear_zero_i |=> overflow_flag_zero_o)
    else $error("flag zero fell without clear");
  a_irq_tracks_flag: assert property (irq_zero_o == overflow_flag_zero_o)
    else $error("irq zero differs from flag zero");
  a_baud_tick_spacing: assert property (baud_tick_o |=> !baud_tick_o [*5])
    else $error("baud ticks closer than a machine cycle");
  a_baud_sets_flag: assert property (
    baud_tick_o && $past(timer_mode_register_i[1:0]) != 2'h3 |-> timer_one_overflow_flag_o)
    else $error("baud tick without flag one");
  // Count output lags the internal count by one clock
  a_stop_holds_low: assert property (
    !run_control_bit_zero_i && !load_zero_i |-> ##2 $stable(count_zero_o.low))
    else $error("timer zero low byte moved while stopped");
  a_split_one_stops: assert property (
    timer_mode_register_i[5:4] == 2'h3 && !load_one_i |-> ##2 $stable(count_one_o))
    else $error("timer one moved in mode 3");
  a_toggle_idle_one: assert property (!toggle_enable_zero_i |=> count_pin_zero_o)
    else $error("pin zero low while toggle off");
  a_toggle_on_ovf: assert property (
    $past(toggle_enable_zero_i) && $past(toggle_enable_zero_i, 2) && $rose(overflow_flag_zero_o)
    |-> $changed(count_pin_zero_o))
    else $error("pin zero kept level on overflow");
endmodule : dual_timer_monitor

bind dual_timer_counter_toggle dual_timer_monitor u_mon (
  .core_clk_i, .rstn_i, .timer_mode_register_i, .run_control_bit_zero_i, .load_zero_i, .load_one_i,
  .flag_clear_zero_i, .toggle_enable_zero_i, .count_pin_zero_o, .overflow_flag_zero_o,
  .timer_one_overflow_flag_o, .irq_zero_o, .baud_tick_o, .count_zero_o, .count_one_o
);

`default_nettype wire

// ==== testbench/count_source.sv ====
// External pulse source on one count pin
`timescale 1ns/100ps
`default_nettype none

module count_source (
  input  wire logic core_clk_i,
  output var  logic pin_o
);
  // ****
  // Pin driver, idles high like the pulled-up port
  // ****
  initial pin_o = 1'b1;

  task automatic pulse(input int n, input int hold);
    int h;
    h = (hold < 6) ? 6 : hold;
    repeat (n) begin
      repeat (h) @(posedge core_clk_i);
      pin_o <= 1'b0;
      repeat (h) @(posedge core_clk_i);
      pin_o <= 1'b1;
    end
  endtask : pulse
endmodule : count_source

`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the dual timer/counter
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  // ****
  // Signals
  // ****
  logic                         core_clk     = 1'b0;
  logic                         rstn         = 1'b0;
  logic [7:0]                   mode         = 8'h00;
  logic [1:0]                   run          = 2'h0;
  logic [1:0]                   ten          = 2'h0;
  logic [1:0]                   clr          = 2'h0;
  logic [1:0]                   ld           = 2'h0;
  logic [1:0]                   gp           = 2'h3;
  dual_timer_pkg::timer_count_t lv           = 16'h0000;
  logic [31:0]                  rnd          = 32'h0000_0203;
  wire  [1:0]                   src;
  wire  [1:0]                   pin;
  wire  [1:0]                   oe;
  wire  [1:0]                   flag;
  wire  [1:0]                   irq;
  wire                          baud;
  wire dual_timer_pkg::timer_count_t c0;
  wire dual_timer_pkg::timer_count_t c1;
  int                           n_errors     = 0;
  int                           total_checks = 0;

  initial forever #12.5 core_clk = ~core_clk;

  dual_timer_counter_toggle dut (
    .core_clk_i(core_clk), .rstn_i(rstn), .timer_mode_register_i(mode),
    .run_control_bit_zero_i(run[0]), .run_control_bit_one_i(run[1]),
    .toggle_enable_zero_i(ten[0]), .toggle_enable_one_i(ten[1]),
    .flag_clear_zero_i(clr[0]), .flag_clear_one_i(clr[1]),
    .load_zero_i(ld[0]), .load_one_i(ld[1]), .load_val_i(lv),
    .count_pin_zero_i(oe[0] ? pin[0] : src[0]), .count_pin_one_i(oe[1] ? pin[1] : src[1]),
    .gating_input_pin_zero_i(gp[0]), .gating_input_pin_one_i(gp[1]),
    .count_pin_zero_o(pin[0]), .count_pin_zero_oe_o(oe[0]),
    .count_pin_one_o(pin[1]), .count_pin_one_oe_o(oe[1]),
    .overflow_flag_zero_o(flag[0]), .timer_one_overflow_flag_o(flag[1]),
    .irq_zero_o(irq[0]), .irq_one_o(irq[1]), .baud_tick_o(baud),
    .count_zero_o(c0), .count_one_o(c1)
  );
  count_source ps0 (.core_clk_i(core_clk), .pin_o(src[0]));
  count_source ps1 (.core_clk_i(core_clk), .pin_o(src[1]));

  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [15:0] cv(input int i);
    return (i == 1) ? c1 : c0;
  endfunction : cv

  function automatic logic [15:0] plus(input logic [15:0] v, input int n);
    return v + n[15:0];
  endfunction : plus

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Returns just after an edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic load(input int i, input logic [15:0] v);
    @(posedge core_clk);
    lv  <= v;
    ld  <= (i == 1) ? 2'h2 : 2'h1;
    clr <= 2'h3;
    @(posedge core_clk);
    ld  <= 2'h0;
    clr <= 2'h0;
    #1;
  endtask : load

  task automatic wait_flag(input int i);
    int k;
    k = 0;
    while (flag[i] !== 1'b1 && k < 2000) begin
      cyc(1);
      k++;
    end
    chk("flag", {15'h0, flag[i]}, 16'h0001);
  endtask : wait_flag

  task automatic sync(input int i);
    logic [15:0] v;
    int          k;
    v = cv(i);
    k = 0;
    while (cv(i) === v && k < 12) begin
      cyc(1);
      k++;
    end
  endtask : sync

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask : fin

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // ****
  // Tests
  // ****
  initial begin
    logic [15:0] v;
    int          n;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    cyc(1);
    chk("rst_pins", {12'h000, pin, oe}, 16'h000c);
    for (int i = 0; i < 2; i++) begin
      rnd = xs(rnd);
      @(posedge core_clk);
      mode <= 8'h11;
      ten  <= 2'h0;
      load(i, rnd[15:0]);
      @(posedge core_clk);
      run <= (i == 1) ? 2'h2 : 2'h1;
      cyc(2);
      chk("start_keeps", {15'h0, plus(rnd[15:0], 1) - cv(i) <= 16'h0001}, 16'h0001);
      sync(i);
      v = cv(i);
      cyc(60);
      chk("rate", cv(i), plus(v, 10));
      @(posedge core_clk);
      run <= 2'h0;
      ten <= 2'h3;
      load(i, 16'hfffd);
      chk("idle_high", {12'h000, pin, oe}, 16'h000f);
      @(posedge core_clk);
      run <= (i == 1) ? 2'h2 : 2'h1;
      wait_flag(i);
      cyc(1);
      chk("wrap", cv(i), 16'h0000);
      chk("toggled", {14'h0, pin[i], irq[i]}, 16'h0001);
      @(posedge core_clk);
      clr <= 2'h3;
      run <= 2'h0;
      @(posedge core_clk);
      clr <= 2'h0;
      cyc(2);
      chk("cleared", {14'h0, flag[i], irq[i]}, 16'h0000);
      fin("rate and overflow");
    end
    @(posedge core_clk);
    mode <= 8'h00;
    ten  <= 2'h0;
    load(0, 16'hffff);
    @(posedge core_clk);
    run <= 2'h1;
    wait_flag(0);
    cyc(1);
    chk("m13_wrap", {c0.high, 3'h0, c0.low[4:0]}, 16'h0000);
    load(0, 16'h00ff);
    // Count output lags a clock; let the loaded value show before waiting
    cyc(1);
    sync(0);
    chk("m13_carry", {c0.high, 3'h0, c0.low[4:0]}, 16'h0100);
    @(posedge core_clk);
    run  <= 2'h0;
    mode <= 8'h20;
    load(1, 16'h80fe);
    @(posedge core_clk);
    run <= 2'h2;
    wait_flag(1);
    cyc(1);
    chk("reload", {c1.high, c1.low & 8'hfe}, 16'h8080);
    fin("mode 0 and 2");
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      run  <= 2'h0;
      mode <= (i == 1) ? 8'h90 : 8'h09;
      gp   <= 2'h0;
      load(i, 16'h0000);
      @(posedge core_clk);
      run <= 2'h3;
      cyc(30);
      chk("gated_off", cv(i), 16'h0000);
      @(posedge core_clk);
      gp <= 2'h3;
      cyc(30);
      chk("gated_on", {15'h0, cv(i) >= 16'h0003}, 16'h0001);
      rnd = xs(rnd);
      n   = int'(rnd[1:0]) + 1;
      @(posedge core_clk);
      run  <= 2'h0;
      mode <= (i == 1) ? 8'h50 : 8'h05;
      load(i, 16'h0000);
      @(posedge core_clk);
      run <= (i == 1) ? 2'h2 : 2'h1;
      if (i == 1) begin
        ps1.pulse(n, 6 + int'(rnd[3:2]));
      end else begin
        ps0.pulse(n, 6 + int'(rnd[3:2]));
      end
      cyc(18);
      chk("edges", cv(i), plus(16'h0000, n));
      fin("gating and counter");
    end
    @(posedge core_clk);
    run  <= 2'h0;
    mode <= 8'h03;
    load(0, 16'hfc00);
    @(posedge core_clk);
    run <= 2'h2;
    wait_flag(1);
    chk("split_low", {c0.low, 7'h0, flag[0]}, 16'h0000);
    @(posedge core_clk);
    mode <= 8'h33;
    cyc(2);
    v = c1;
    cyc(30);
    chk("t1_mode3", c1, v);
    @(posedge core_clk);
    mode <= 8'h23;
    load(1, 16'hfffe);
    n = 0;
    repeat (60) begin
      cyc(1);
      n += int'(baud);
    end
    chk("baud", {15'h0, n >= 8 && n <= 10}, 16'h0001);
    chk("no_flag1", {15'h0, flag[1]}, 16'h0000);
    fin("split mode");
    final_report();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    final_report();
  end
endmodule : tb_top

`default_nettype wire
